//--- hdl/ars_pkg.sv
/*
 Constants shared by the auto-range scale selector: register map, field
 positions, reset values, operating modes and AXI4-Lite response codes.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package ars_pkg;
    localparam int POS_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register positions A to D, A in bit 0
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_C = 2;
    localparam int IDX_D = 3;

    // Single zero bit at D, the highest voltage scale, is the safe start
    localparam logic [POS_W-1:0] POS_RESET = 4'h7;
    // Fill bits entering the register when the zero bit moves
    localparam logic [POS_W-1:0] FILL_LOW = 4'h1;
    localparam logic [POS_W-1:0] FILL_HIGH = 4'h8;
    localparam logic [POS_W-1:0] POS_ALL_ONES = 4'hF;

    typedef enum logic [1:0] {
        ARS_VOLTS_DIRECT_MODE,
        ARS_VOLTS_ALTERNATING_MODE,
        ARS_OHMS_MODE,
        ARS_MODE_SPARE
    } ars_mode_e;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_POSITION = 8'h08;

    // CTRL fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_MSB = 2;
    localparam logic CTRL_AUTO_RESET = 1'b1;

    // STATUS fields
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_POS_MSB = 3;
    localparam int STAT_OVER_BIT = 4;
    localparam int STAT_UNDER_BIT = 5;
    localparam int STAT_END_BIT = 6;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_CNT_MSB = 15;
    localparam int CNT_W = 8;

    // POSITION fields
    localparam int POSN_LSB = 0;
    localparam int POSN_MSB = 1;
    localparam int SEL_W = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/ars_shift_if.sv
/*
 Request and state wires between the auto-range controller and the
 scale shift register. Assumes both ends share one clock.
*/
interface ars_shift_if;
    logic toward_d;
    logic toward_a;
    logic load;
    logic [ars_pkg::SEL_W-1:0] load_sel;
    logic [ars_pkg::POS_W-1:0] pos;

    modport ctrl (output toward_d, output toward_a, output load, output load_sel, input pos);
    modport store (input toward_d, input toward_a, input load, input load_sel, output pos);
endinterface

//--- hdl/ars_range_shifter.sv
/*
 Four-position shift register holding a single zero bit that marks the
 active scale. Assumes the controller never asks for two moves at once.
*/
module ars_range_shifter (
    input wire logic clk_in,
    input wire logic rst_in,
    ars_shift_if.store sr
);
    logic [ars_pkg::POS_W-1:0] pos;
    logic [ars_pkg::POS_W-1:0] next_pos;

    always_comb begin
        next_pos = pos;
        if (sr.load) begin
            next_pos = ars_pkg::POS_ALL_ONES;
            next_pos[sr.load_sel] = 1'b0;
        end else if (sr.toward_d && sr.pos[ars_pkg::IDX_D]) begin
            next_pos = (pos << 1) | ars_pkg::FILL_LOW;
        end else if (sr.toward_a && sr.pos[ars_pkg::IDX_A]) begin
            next_pos = (pos >> 1) | ars_pkg::FILL_HIGH;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pos <= ars_pkg::POS_RESET;
        end else begin
            pos <= next_pos;
        end
    end

    assign sr.pos = pos;
endmodule // ars_range_shifter

//--- hdl/ars_autorange.sv
/*
 Auto-range scale selector with AXI4-Lite registers: steps a single zero
 bit across four scales on converter over/under-range reports and drives
 the divider relays, decimal points and range indicator.
 Assumes conversion reports are synchronous to CLK_IN, with CONV_DONE_IN
 a one-cycle pulse qualifying OVER_RANGE_IN and UNDER_RANGE_IN.
*/
// The AXI4-Lite slave port and the register addresses were left to the implementer.
// What this block does
// - Exactly one zero bit among positions A-D selects relay and decimal point.
// - Each conversion with only one range flag set moves the zero bit one step; in range or both flags holds it.
// - Volts: B lights left point, C middle, A or D right.
// - Ohms: D or A lights left point, C middle, B right.
// - Range indicator follows position A to split shared-point scales.
// - A move past either end is blocked so the zero bit never leaves.
module ars_autorange (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [ars_pkg::ADDR_W-1:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [ars_pkg::DATA_W-1:0] AXI_WDATA_IN,
    input wire logic [ars_pkg::STRB_W-1:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    input wire logic [ars_pkg::ADDR_W-1:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [ars_pkg::DATA_W-1:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    input wire logic CONV_DONE_IN,
    input wire logic OVER_RANGE_IN,
    input wire logic UNDER_RANGE_IN,
    output logic [ars_pkg::POS_W-1:0] RELAY_OUT,
    output logic POINT_LEFT_OUT,
    output logic POINT_MIDDLE_OUT,
    output logic POINT_RIGHT_OUT,
    output logic RANGE_LOW_OUT
);
    ars_shift_if sr ();

    ars_range_shifter u_shifter (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .sr(sr.store)
    );

    // Bus slave state
    logic aw_held, next_aw_held;
    logic [ars_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [ars_pkg::DATA_W-1:0] w_data, next_w_data;
    logic [ars_pkg::STRB_W-1:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [ars_pkg::DATA_W-1:0] rdata, next_rdata;

    // Control and status state
    logic auto_en, next_auto_en;
    ars_pkg::ars_mode_e mode, next_mode;
    logic last_over, next_last_over;
    logic last_under, next_last_under;
    logic end_hit, next_end_hit;
    logic [ars_pkg::CNT_W-1:0] shift_cnt, next_shift_cnt;

    // Output state
    logic [ars_pkg::POS_W-1:0] relay, next_relay;
    logic point_left, next_point_left;
    logic point_middle, next_point_middle;
    logic point_right, next_point_right;
    logic range_low, next_range_low;

    logic do_write;
    logic wr_lane0;
    logic ohms;
    logic conv;
    logic blocked;
    logic [ars_pkg::POS_W-1:0] zero;
    logic [ars_pkg::SEL_W-1:0] zero_idx;
    logic [ars_pkg::DATA_W-1:0] rd_mux;
    logic rd_hit;

    assign zero = ~sr.pos;
    assign ohms = (mode == ars_pkg::ARS_OHMS_MODE);
    assign conv = CONV_DONE_IN && auto_en;

    // Ohm ladder runs opposite to the voltage ladder, so over-range heads to A there
    always_comb begin
        sr.toward_d = 1'b0;
        sr.toward_a = 1'b0;
        if (conv && (OVER_RANGE_IN != UNDER_RANGE_IN)) begin
            sr.toward_d = ohms ? UNDER_RANGE_IN : OVER_RANGE_IN;
            sr.toward_a = ohms ? OVER_RANGE_IN : UNDER_RANGE_IN;
        end
    end

    assign blocked = (sr.toward_d && !sr.pos[ars_pkg::IDX_D]) ||
                     (sr.toward_a && !sr.pos[ars_pkg::IDX_A]);

    always_comb begin
        zero_idx = '0;
        for (int i = 0; i < ars_pkg::POS_W; i++) begin
            if (zero[i]) begin
                zero_idx = i[ars_pkg::SEL_W-1:0];
            end
        end
    end

    // Write channel: address and data may arrive in either order
    assign AXI_AWREADY_OUT = !aw_held && !bvalid;
    assign AXI_WREADY_OUT = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_lane0 = do_write && w_strb[0];

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
            next_aw_held = 1'b1;
            next_aw_addr = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
            next_w_held = 1'b1;
            next_w_data = AXI_WDATA_IN;
            next_w_strb = AXI_WSTRB_IN;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if ((aw_addr == ars_pkg::OFF_CTRL) || (aw_addr == ars_pkg::OFF_STATUS) ||
                (aw_addr == ars_pkg::OFF_POSITION)) begin
                next_bresp = ars_pkg::RESP_OKAY;
            end else begin
                next_bresp = ars_pkg::RESP_SLVERR;
            end
        end
        if (bvalid && AXI_BREADY_IN) begin
            next_bvalid = 1'b0;
        end
    end

    // Manual scale selection only while auto-ranging is off
    always_comb begin
        sr.load = wr_lane0 && (aw_addr == ars_pkg::OFF_POSITION) && !auto_en;
        sr.load_sel = w_data[ars_pkg::POSN_MSB:ars_pkg::POSN_LSB];
    end

    always_comb begin
        next_auto_en = auto_en;
        next_mode = mode;
        next_last_over = last_over;
        next_last_under = last_under;
        next_end_hit = end_hit;
        next_shift_cnt = shift_cnt;
        if (wr_lane0 && (aw_addr == ars_pkg::OFF_CTRL)) begin
            next_auto_en = w_data[ars_pkg::CTRL_AUTO_BIT];
            next_mode = ars_pkg::ars_mode_e'(w_data[ars_pkg::CTRL_MODE_MSB:ars_pkg::CTRL_MODE_LSB]);
        end
        if (wr_lane0 && (aw_addr == ars_pkg::OFF_STATUS) && w_data[ars_pkg::STAT_END_BIT]) begin
            next_end_hit = 1'b0;
        end
        if (blocked) begin
            next_end_hit = 1'b1;
        end
        if (CONV_DONE_IN) begin
            next_last_over = OVER_RANGE_IN;
            next_last_under = UNDER_RANGE_IN;
        end
        if ((sr.toward_d || sr.toward_a) && !blocked) begin
            next_shift_cnt = shift_cnt + 1'b1;
        end
    end

    // Read channel: one cycle from address to data
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        case (AXI_ARADDR_IN)
            ars_pkg::OFF_CTRL: begin
                rd_mux[ars_pkg::CTRL_AUTO_BIT] = auto_en;
                rd_mux[ars_pkg::CTRL_MODE_MSB:ars_pkg::CTRL_MODE_LSB] = mode;
            end
            ars_pkg::OFF_STATUS: begin
                rd_mux[ars_pkg::STAT_POS_MSB:ars_pkg::STAT_POS_LSB] = sr.pos;
                rd_mux[ars_pkg::STAT_OVER_BIT] = last_over;
                rd_mux[ars_pkg::STAT_UNDER_BIT] = last_under;
                rd_mux[ars_pkg::STAT_END_BIT] = end_hit;
                rd_mux[ars_pkg::STAT_CNT_MSB:ars_pkg::STAT_CNT_LSB] = shift_cnt;
            end
            ars_pkg::OFF_POSITION: begin
                rd_mux[ars_pkg::POSN_MSB:ars_pkg::POSN_LSB] = zero_idx;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign AXI_ARREADY_OUT = !rvalid;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            next_rvalid = 1'b1;
            next_rdata = rd_mux;
            next_rresp = rd_hit ? ars_pkg::RESP_OKAY : ars_pkg::RESP_SLVERR;
        end else if (rvalid && AXI_RREADY_IN) begin
            next_rvalid = 1'b0;
        end
    end

    // Relay drive, one per position
    for (genvar g = 0; g < ars_pkg::POS_W; g++) begin : g_relay
        assign next_relay[g] = zero[g];
    end

    always_comb begin
        if (ohms) begin
            next_point_left = zero[ars_pkg::IDX_D] || zero[ars_pkg::IDX_A];
            next_point_middle = zero[ars_pkg::IDX_C];
            next_point_right = zero[ars_pkg::IDX_B];
        end else begin
            next_point_left = zero[ars_pkg::IDX_B];
            next_point_middle = zero[ars_pkg::IDX_C];
            next_point_right = zero[ars_pkg::IDX_A] || zero[ars_pkg::IDX_D];
        end
        next_range_low = zero[ars_pkg::IDX_A];
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= ars_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= ars_pkg::RESP_OKAY;
            rdata <= '0;
            auto_en <= ars_pkg::CTRL_AUTO_RESET;
            mode <= ars_pkg::ARS_VOLTS_DIRECT_MODE;
            last_over <= 1'b0;
            last_under <= 1'b0;
            end_hit <= 1'b0;
            shift_cnt <= '0;
            relay <= '0;
            point_left <= 1'b0;
            point_middle <= 1'b0;
            point_right <= 1'b0;
            range_low <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            auto_en <= next_auto_en;
            mode <= next_mode;
            last_over <= next_last_over;
            last_under <= next_last_under;
            end_hit <= next_end_hit;
            shift_cnt <= next_shift_cnt;
            relay <= next_relay;
            point_left <= next_point_left;
            point_middle <= next_point_middle;
            point_right <= next_point_right;
            range_low <= next_range_low;
        end
    end

    assign AXI_BVALID_OUT = bvalid;
    assign AXI_BRESP_OUT = bresp;
    assign AXI_RVALID_OUT = rvalid;
    assign AXI_RRESP_OUT = rresp;
    assign AXI_RDATA_OUT = rdata;
    assign RELAY_OUT = relay;
    assign POINT_LEFT_OUT = point_left;
    assign POINT_MIDDLE_OUT = point_middle;
    assign POINT_RIGHT_OUT = point_right;
    assign RANGE_LOW_OUT = range_low;

    property p_one_zero;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        ($countones(zero) == 1) && ($countones(RELAY_OUT) <= 1);
    endproperty
    a_one_zero: assert property (p_one_zero) else $error("Zero bit count not one");

    property p_step_d;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        (sr.toward_d && sr.pos[ars_pkg::IDX_D]) |=> (sr.pos == (($past(sr.pos) << 1) | ars_pkg::FILL_LOW))
            ##1 (RELAY_OUT == ~$past(sr.pos));
    endproperty
    a_step_d: assert property (p_step_d) else $error("Step toward D wrong");

    property p_step_a;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        (sr.toward_a && sr.pos[ars_pkg::IDX_A]) |=> (sr.pos == (($past(sr.pos) >> 1) | ars_pkg::FILL_HIGH));
    endproperty
    a_step_a: assert property (p_step_a) else $error("Step toward A wrong");

    property p_hold_in_range;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        (CONV_DONE_IN && !OVER_RANGE_IN && !UNDER_RANGE_IN && auto_en) |=> $stable(sr.pos);
    endproperty
    a_hold_in_range: assert property (p_hold_in_range) else $error("Scale moved on in-range reading");

    property p_points_volts;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        ($past(mode) != ars_pkg::ARS_OHMS_MODE) |-> (POINT_LEFT_OUT == RELAY_OUT[ars_pkg::IDX_B]) &&
            (POINT_MIDDLE_OUT == RELAY_OUT[ars_pkg::IDX_C]) &&
            (POINT_RIGHT_OUT == (RELAY_OUT[ars_pkg::IDX_A] || RELAY_OUT[ars_pkg::IDX_D]));
    endproperty
    a_points_volts: assert property (p_points_volts) else $error("Volt decimal point wrong");

    property p_points_ohms;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        ($past(mode) == ars_pkg::ARS_OHMS_MODE) |-> (POINT_RIGHT_OUT == RELAY_OUT[ars_pkg::IDX_B]) &&
            (POINT_MIDDLE_OUT == RELAY_OUT[ars_pkg::IDX_C]) &&
            (POINT_LEFT_OUT == (RELAY_OUT[ars_pkg::IDX_A] || RELAY_OUT[ars_pkg::IDX_D]));
    endproperty
    a_points_ohms: assert property (p_points_ohms) else $error("Ohm decimal point wrong");

    property p_range_low;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        RANGE_LOW_OUT == !$past(sr.pos[ars_pkg::IDX_A]);
    endproperty
    a_range_low: assert property (p_range_low) else $error("Range indicator not following A");

    property p_end_gate;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        blocked |=> $stable(sr.pos) && end_hit;
    endproperty
    a_end_gate: assert property (p_end_gate) else $error("Zero bit pushed past range end");

    property p_reset_pos;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        $fell(SYS_RST_IN) |-> (sr.pos == ars_pkg::POS_RESET) ##1 (RELAY_OUT == ~ars_pkg::POS_RESET);
    endproperty
    a_reset_pos: assert property (p_reset_pos) else $error("Reset position wrong");
endmodule // ars_autorange

//--- tb/ars_conv_model.sv
/*
 Behavioural model of the converter pair: on a start request it waits a chosen
 lag, then pulses conversion done with over/under worked out from the wanted
 scale against the scale that the relays select.
 Assumes one clock shared with the selector, synchronous active-high reset.
*/
module ars_conv_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic both_in,
    input wire logic ohms_in,
    input wire logic signed [3:0] level_in,
    input wire logic [3:0] lag_in,
    input wire logic [ars_pkg::POS_W-1:0] relay_in,
    output logic done_out,
    output logic over_out,
    output logic under_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] left;
    logic signed [3:0] cur;
    logic above;
    logic below;

    always_comb begin
        cur = relay_in[3] ? 4'sh3 : relay_in[2] ? 4'sh2 : relay_in[1] ? 4'sh1 : 4'sh0;
        above = level_in > cur;
        below = level_in < cur;
    end

    // Range flags toggle outside the done pulse so stale values never look valid
    always @(posedge clk_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            left <= 4'h0;
            done_out <= 1'b0;
            over_out <= 1'b0;
            under_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            over_out <= ~over_out;
            under_out <= ~under_out;
            if (go_in) begin
                busy <= 1'b1;
                left <= lag_in;
            end else if (busy && left != 4'h0) begin
                left <= left - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                done_out <= 1'b1;
                over_out <= both_in || (ohms_in ? below : above);
                under_out <= both_in || (ohms_in ? above : below);
            end
        end
    end
endmodule // ars_conv_model

//--- tb/tb_top.sv
/*
 Self-checking bench for the auto-range selector: AXI4-Lite master tasks,
 converter model on the range inputs, scenario tasks and closing report.
 Assumes the selector and package from hdl/ and the model from tb/.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic go = 1'b0;
    logic both = 1'b0;
    logic signed [3:0] level = 4'sh0;
    logic [3:0] lag = 4'h0;
    logic [1:0] mode = 2'h0;
    logic done, over, under, awready, wready, bvalid, arready, rvalid, pl, pm, pr, low;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] relay;
    logic [7:0] moves = 8'h00;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int idx = 3;

    ars_autorange u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
        .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid),
        .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
        .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .CONV_DONE_IN(done),
        .OVER_RANGE_IN(over), .UNDER_RANGE_IN(under), .RELAY_OUT(relay), .POINT_LEFT_OUT(pl),
        .POINT_MIDDLE_OUT(pm), .POINT_RIGHT_OUT(pr), .RANGE_LOW_OUT(low));

    ars_conv_model u_conv (.clk_in(clk), .rst_in(rst), .go_in(go), .both_in(both),
        .ohms_in(mode == ars_pkg::ARS_OHMS_MODE), .level_in(level), .lag_in(lag), .relay_in(relay),
        .done_out(done), .over_out(over), .under_out(under));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, b_hit;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
        end while (!b_hit);
        bready <= 1'b0;
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string name);
        logic ar_hit, r_hit;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hit)
                arvalid <= 1'b0;
        end while (!r_hit);
        rready <= 1'b0;
        check(name, d, ed);
        check("rresp", {30'h0, r}, {30'h0, er});
    endtask

    // One conversion through the model, then wait for the move and the output update
    task automatic conv(input logic signed [3:0] lv, input logic bo, input logic [3:0] lg);
        int n;
        @(posedge clk);
        go <= 1'b1;
        level <= lv;
        both <= bo;
        lag <= lg;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!done && n < 40);
        check("conv done", {31'h0, done}, 32'h0000_0001);
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic chk_out(input int i);
        logic [7:0] e;
        logic ohm;
        // Registered outputs settle only after the edge that launches them
        @(negedge clk);
        ohm = (mode == ars_pkg::ARS_OHMS_MODE);
        e[7:4] = 4'h1 << i;
        e[3] = ohm ? (i == 3 || i == 0) : (i == 1);
        e[2] = (i == 2);
        e[1] = ohm ? (i == 1) : (i == 0 || i == 3);
        e[0] = (i == 0);
        check("outputs", {24'h0, relay, pl, pm, pr, low}, {24'h0, e});
    endtask

    task automatic t_bus;
        axi_wr(8'h0C, 32'h0000_0001, ars_pkg::RESP_SLVERR);
        axi_rd(8'h0C, 32'h0000_0000, ars_pkg::RESP_SLVERR, "unmapped");
        axi_rd(ars_pkg::OFF_CTRL, 32'h0000_0001, ars_pkg::RESP_OKAY, "ctrl");
        axi_rd(ars_pkg::OFF_STATUS, 32'h0000_0007, ars_pkg::RESP_OKAY, "status");
    endtask

    // Walk to the A end and past it, then to the D end and past it
    task automatic walk(input logic [1:0] m, input logic [3:0] lg);
        mode = m;
        axi_wr(ars_pkg::OFF_CTRL, {29'h0, m, 1'b1}, ars_pkg::RESP_OKAY);
        axi_wr(ars_pkg::OFF_STATUS, 32'h0000_0040, ars_pkg::RESP_OKAY);
        chk_out(idx);
        for (int k = 0; k < 8; k++) begin
            conv(k < 4 ? 4'shF : 4'sh4, 1'b0, lg);
            if ((k < 4 && idx > 0) || (k >= 4 && idx < 3)) begin
                idx = (k < 4) ? idx - 1 : idx + 1;
                moves++;
            end
            chk_out(idx);
        end
        axi_rd(ars_pkg::OFF_STATUS, {16'h0, moves, 2'b01, (m == ars_pkg::ARS_OHMS_MODE) ? 2'b10 : 2'b01, 4'h7},
            ars_pkg::RESP_OKAY, "status");
    endtask

    task automatic t_refuse;
        mode = 2'h0;
        axi_wr(ars_pkg::OFF_CTRL, 32'h0000_0001, ars_pkg::RESP_OKAY);
        conv(4'sh3, 1'b1, 4'h0);
        chk_out(3);
        conv(4'sh3, 1'b0, 4'h1);
        chk_out(3);
        axi_wr(ars_pkg::OFF_POSITION, 32'h0000_0000, ars_pkg::RESP_OKAY);
        chk_out(3);
        axi_wr(ars_pkg::OFF_CTRL, 32'h0000_0000, ars_pkg::RESP_OKAY);
        conv(4'shF, 1'b0, 4'h0);
        chk_out(3);
        axi_wr(ars_pkg::OFF_POSITION, 32'h0000_0001, ars_pkg::RESP_OKAY);
        chk_out(1);
        axi_rd(ars_pkg::OFF_POSITION, 32'h0000_0001, ars_pkg::RESP_OKAY, "position");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_out(3);
        t_bus();
        walk(ars_pkg::ARS_VOLTS_DIRECT_MODE, 4'h0);
        walk(ars_pkg::ARS_VOLTS_ALTERNATING_MODE, 4'h2);
        walk(ars_pkg::ARS_OHMS_MODE, 4'h5);
        walk(ars_pkg::ARS_MODE_SPARE, 4'h0);
        t_refuse();
        wrap_up();
    end
endmodule // tb_top
